// *** src/fbd_decode.sv ***
// Instruction decoder of the 4-bit core with branch target formation.
// Assumes program memory presents a word with a one-cycle valid strobe.
`timescale 1ns/1ns

// Notes on behaviour
// - Branch field is the low 11 target bits
// - PC bits 12..11 select the page
// - Segment register holds PC bit 13
// - System call entry fills bits 10..8, 3..0
// - Peripheral address is high 3, low 4
// - Register file address is row 3, column 4
// - Data memory address is row then column
// - Return stack entry chosen by stack pointer
// - Interrupt acceptance saves registers automatically
module fbd_decode
	import fbd_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	input wire logic [13:0] pc,
	input wire logic [13:0] address_reg,
	input wire logic [3:0] auto_saved_regs,
	input wire logic irq_accept,
	input wire logic segment_load,
	input wire logic segment_value,
	output logic dec_valid,
	output fbd_class_t op_class,
	output logic [3:0] op_code,
	output logic op_form,
	output logic [3:0] sub_sel,
	output logic [6:0] mem_addr,
	output logic [6:0] periph_addr,
	output logic [6:0] regfile_addr_field,
	output logic [3:0] imm,
	output logic [13:0] branch_target,
	output logic [13:0] return_stack_entry,
	output logic [2:0] stack_ptr,
	output logic segment_bit_reg,
	output logic [3:0] interrupt_save_stack
);
	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [6:0] f_mem; // Combinational fields from the extractor
	logic [6:0] f_periph;
	logic [6:0] f_rf;
	logic [3:0] f_imm;
	logic [10:0] f_sys;
	fbd_class_t next_class; // Decoded class for this word
	logic [13:0] next_target; // Decoded target for this word
	logic [13:0] ret_stack [0:7]; // Return address stack storage
	logic stack_push; // Call or push decoded
	logic stack_pop; // Return or pop decoded
	logic [2:0] sp_dec; // Pointer after pre-decrement

	fbd_fields u_fields
	(
		.instr(instr),
		.mem_addr(f_mem),
		.periph_addr(f_periph),
		.regfile_addr_field(f_rf),
		.imm(f_imm),
		.sys_target(f_sys)
	);

	// Special group member test, used by several decodes
	function automatic logic is_special(input logic [15:0] w, input logic [3:0] sel);
		is_special = !w[FBD_FORM_BIT] && w[FBD_OP_HI:FBD_OP_LO] == FBD_OP_SPECIAL
			&& w[FBD_COL_HI:FBD_COL_LO] == sel;
	endfunction

	// ------------------------------------------------------------------
	// Class decode
	// ------------------------------------------------------------------
	// Opcode plus form bit picks the class
	always_comb
	begin
		next_class = FBD_C_NONE;
		case (instr[FBD_OP_HI:FBD_OP_LO])
			4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6:
			begin
				next_class = instr[FBD_FORM_BIT] ? FBD_C_ALU_MI : FBD_C_ALU_RM;
			end
			4'h7:
			begin
				// Special group, further bits choose member
				if (instr[FBD_FORM_BIT])
					next_class = FBD_C_NONE;
				else if (is_special(instr, FBD_SEL_SYS))
					next_class = FBD_C_SYSCALL;
				else if (is_special(instr, FBD_SEL_PUSH) || is_special(instr, FBD_SEL_POP))
					next_class = FBD_C_STACK;
				else if (is_special(instr, FBD_SEL_GET) || is_special(instr, FBD_SEL_PUT))
					next_class = FBD_C_PERIPH;
				else if (is_special(instr, FBD_SEL_RET))
					next_class = FBD_C_RET;
				else
					next_class = FBD_C_SPECIAL;
			end
			4'h8, 4'ha:
			begin
				next_class = FBD_C_XFER;
			end
			4'h9, 4'hb:
			begin
				next_class = FBD_C_SKIP;
			end
			4'hc:
			begin
				next_class = instr[FBD_FORM_BIT] ? FBD_C_CALL : FBD_C_BR;
			end
			4'hd:
			begin
				next_class = instr[FBD_FORM_BIT] ? FBD_C_XFER : FBD_C_BR;
			end
			4'he, 4'hf:
			begin
				next_class = instr[FBD_FORM_BIT] ? FBD_C_SKIP : FBD_C_BR;
			end
			default:
			begin
				next_class = FBD_C_NONE;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Target formation
	// ------------------------------------------------------------------
	// Direct branch: segment, page from opcode, 11-bit field
	always_comb
	begin
		next_target = pc;
		case (next_class)
			FBD_C_BR:
			begin
				next_target = {segment_bit_reg, instr[12:11], instr[10:0]};
			end
			FBD_C_CALL:
			begin
				next_target = {segment_bit_reg, 2'b00, instr[10:0]};
			end
			FBD_C_SYSCALL:
			begin
				// Stays in current segment, page 0
				next_target = {segment_bit_reg, 2'b00, f_sys};
			end
			FBD_C_SPECIAL:
			begin
				// Indirect forms jump through the address register
				next_target = address_reg;
			end
			FBD_C_RET:
			begin
				next_target = ret_stack[stack_ptr];
			end
			default:
			begin
				next_target = pc;
			end
		endcase
	end

	assign stack_push = instr_valid && (next_class == FBD_C_CALL || next_class == FBD_C_SYSCALL
		|| is_special(instr, FBD_SEL_PUSH));
	assign stack_pop = instr_valid && (next_class == FBD_C_RET || is_special(instr, FBD_SEL_POP));
	assign sp_dec = stack_ptr - 3'd1;

	// ------------------------------------------------------------------
	// Registered decode outputs
	// ------------------------------------------------------------------
	// Latch fields each valid word
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			dec_valid <= 1'b0;
			op_class <= FBD_C_NONE;
			op_code <= 4'h0;
			op_form <= 1'b0;
			sub_sel <= 4'h0;
			mem_addr <= 7'h00;
			periph_addr <= 7'h00;
			regfile_addr_field <= 7'h00;
			imm <= 4'h0;
			branch_target <= FBD_PC_RST;
		end
		else
		begin
			dec_valid <= instr_valid;
			if (instr_valid)
			begin
				op_class <= next_class;
				op_code <= instr[FBD_OP_HI:FBD_OP_LO];
				op_form <= instr[FBD_FORM_BIT];
				sub_sel <= instr[FBD_COL_HI:FBD_COL_LO];
				mem_addr <= f_mem;
				periph_addr <= f_periph;
				regfile_addr_field <= f_rf;
				imm <= f_imm;
				branch_target <= next_target;
			end
		end
	end

	// ------------------------------------------------------------------
	// Segment register
	// ------------------------------------------------------------------
	// Bit 13 changes only on reset or an explicit load
	always_ff @(posedge clk)
	begin
		if (reset)
			segment_bit_reg <= FBD_PC_RST[13];
		else if (segment_load)
			segment_bit_reg <= segment_value;
	end

	// ------------------------------------------------------------------
	// Return stack
	// ------------------------------------------------------------------
	// Pointer pre-decrements on push, post-increments on pop
	always_ff @(posedge clk)
	begin
		if (reset)
			stack_ptr <= FBD_SP_RST;
		else if (stack_push)
			stack_ptr <= sp_dec;
		else if (stack_pop)
			stack_ptr <= stack_ptr + 3'd1;
	end

	// Calls save next pc, push saves the address register
	always_ff @(posedge clk)
	begin
		if (stack_push)
			ret_stack[sp_dec] <= is_special(instr, FBD_SEL_PUSH) ? address_reg : pc + 14'd1;
	end

	// Entry at current pointer, visible to the datapath
	always_ff @(posedge clk)
	begin
		if (reset)
			return_stack_entry <= FBD_PC_RST;
		else
			return_stack_entry <= ret_stack[stack_ptr];
	end

	// ------------------------------------------------------------------
	// Interrupt save
	// ------------------------------------------------------------------
	// Hardware copy, no software step involved
	always_ff @(posedge clk)
	begin
		if (reset)
			interrupt_save_stack <= 4'h0;
		else if (irq_accept)
			interrupt_save_stack <= auto_saved_regs;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence s_br_taken;
		instr_valid && next_class == FBD_C_BR;
	endsequence

	branch_low_bits_a: assert property (@(posedge clk) disable iff (reset)
		s_br_taken |=> branch_target[10:0] == $past(instr[10:0]))
		else $error("branch low bits wrong");
	branch_page_a: assert property (@(posedge clk) disable iff (reset)
		s_br_taken |=> branch_target[12:11] == $past(instr[12:11]))
		else $error("branch page wrong");
	branch_segment_a: assert property (@(posedge clk) disable iff (reset)
		s_br_taken |=> branch_target[13] == $past(segment_bit_reg))
		else $error("branch segment wrong");
	syscall_entry_a: assert property (@(posedge clk) disable iff (reset)
		instr_valid && next_class == FBD_C_SYSCALL |=> branch_target[10:0]
		== {$past(instr[10:8]), 4'h0, $past(instr[3:0])})
		else $error("syscall entry wrong");
	periph_address_a: assert property (@(posedge clk) disable iff (reset)
		instr_valid |=> periph_addr == {$past(instr[10:8]), $past(instr[3:0])})
		else $error("peripheral address wrong");
	regfile_address_a: assert property (@(posedge clk) disable iff (reset)
		instr_valid |=> regfile_addr_field == {$past(instr[10:8]), $past(instr[7:4])})
		else $error("register file address wrong");
	mem_address_a: assert property (@(posedge clk) disable iff (reset)
		instr_valid |=> mem_addr == $past(instr[10:4]))
		else $error("memory address wrong");
	stack_pointer_a: assert property (@(posedge clk) disable iff (reset)
		stack_push |=> stack_ptr == $past(stack_ptr) - 3'd1)
		else $error("stack pointer not decremented");
	irq_save_a: assert property (@(posedge clk) disable iff (reset)
		irq_accept |=> interrupt_save_stack == $past(auto_saved_regs))
		else $error("interrupt save missed");
	special_group_a: assert property (@(posedge clk) disable iff (reset)
		instr_valid && !instr[15] && instr[14:11] == 4'h7 |=> op_class inside
		{FBD_C_SPECIAL, FBD_C_SYSCALL, FBD_C_STACK, FBD_C_PERIPH, FBD_C_RET})
		else $error("special group misdecoded");
	opcode_form_a: assert property (@(posedge clk) disable iff (reset)
		instr_valid |=> op_code == $past(instr[14:11]) && op_form == $past(instr[15]))
		else $error("opcode or form wrong");
endmodule

// *** src/fbd_fields.sv ***
// Field extractor: splits an instruction word into operand fields.
// Assumes a registered, stable instruction word on the same clock.
`timescale 1ns/1ns
module fbd_fields
	import fbd_pkg::*;
(
	input wire logic [15:0] instr,
	output logic [6:0] mem_addr,
	output logic [6:0] periph_addr,
	output logic [6:0] regfile_addr_field,
	output logic [3:0] imm,
	output logic [10:0] sys_target
);
	// ------------------------------------------------------------------
	// Field combination
	// ------------------------------------------------------------------
	logic [2:0] mem_row_field; // Row, high-order part
	logic [3:0] mem_col_field; // Column, low-order part
	logic [2:0] periph_addr_high; // Shares the row slot
	logic [3:0] periph_addr_low; // Shares the low nibble slot

	assign mem_row_field = instr[FBD_ROW_HI:FBD_ROW_LO];
	assign mem_col_field = instr[FBD_COL_HI:FBD_COL_LO];
	assign periph_addr_high = instr[FBD_ROW_HI:FBD_ROW_LO];
	assign periph_addr_low = instr[FBD_LOW_HI:FBD_LOW_LO];
	// Row above column
	assign mem_addr = {mem_row_field, mem_col_field};
	// High 3 bits above low 4 bits
	assign periph_addr = {periph_addr_high, periph_addr_low};
	// Register file row above column, same slots as memory
	assign regfile_addr_field = {instr[FBD_ROW_HI:FBD_ROW_LO], instr[FBD_COL_HI:FBD_COL_LO]};
	// Immediate, bit position or general register column
	assign imm = instr[FBD_LOW_HI:FBD_LOW_LO];
	// Entry split: bits 10..8 and 3..0, the rest zero
	assign sys_target = {instr[FBD_ROW_HI:FBD_ROW_LO], 4'h0, instr[FBD_LOW_HI:FBD_LOW_LO]};
endmodule

// *** src/fbd_pkg.sv ***
// Package for the 4-bit core instruction decoder: field layouts and codes.
// Assumes a 16-bit instruction word and a 14-bit program counter.
package fbd_pkg;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int FBD_FORM_BIT = 15; // Register-memory versus immediate form
	localparam int FBD_OP_HI = 14; // Main operation code top bit
	localparam int FBD_OP_LO = 11; // Main operation code low bit
	localparam int FBD_ROW_HI = 10; // Row / high-part field
	localparam int FBD_ROW_LO = 8;
	localparam int FBD_COL_HI = 7; // Column / selector field
	localparam int FBD_COL_LO = 4;
	localparam int FBD_LOW_HI = 3; // Low nibble field
	localparam int FBD_LOW_LO = 0;
	localparam int FBD_ADDR_W = 11; // In-page branch address width
	localparam int FBD_PC_W = 14; // Full program counter width
	localparam int FBD_SP_W = 3; // Return stack pointer width

	// ------------------------------------------------------------------
	// Main operation codes
	// ------------------------------------------------------------------
	localparam logic [3:0] FBD_OP_SPECIAL = 4'h7; // Special group with bit 15 clear
	localparam logic [3:0] FBD_OP_CALL0 = 4'hc; // Call page 0 when bit 15 set

	// Special group selector codes (bits 7..4)
	localparam logic [3:0] FBD_SEL_MOVT = 4'h1;
	localparam logic [3:0] FBD_SEL_ROTATE_THROUGH_CARRY_OP = 4'h7;
	localparam logic [3:0] FBD_SEL_INCIX = 4'h8;
	localparam logic [3:0] FBD_SEL_INCAR = 4'h9;
	localparam logic [3:0] FBD_SEL_PUT = 4'ha;
	localparam logic [3:0] FBD_SEL_GET = 4'hb;
	localparam logic [3:0] FBD_SEL_POP = 4'hc;
	localparam logic [3:0] FBD_SEL_PUSH = 4'hd;
	localparam logic [3:0] FBD_SEL_RET = 4'he;
	localparam logic [3:0] FBD_SEL_SYS = 4'hf;

	// Reset values
	localparam logic [13:0] FBD_PC_RST = 14'h0000;
	localparam logic [2:0] FBD_SP_RST = 3'h7;

	// Operation classes
	typedef enum logic [3:0] {
		FBD_C_NONE, FBD_C_ALU_RM, FBD_C_ALU_MI, FBD_C_SKIP, FBD_C_XFER,
		FBD_C_BR, FBD_C_CALL, FBD_C_SPECIAL, FBD_C_SYSCALL, FBD_C_STACK,
		FBD_C_PERIPH, FBD_C_RET
	} fbd_class_t;

endpackage

// *** verif/fbd_prog_mem.sv ***
// Program memory model: presents one instruction word per fetch request.
// Assumes the bench raises fetch_req for one cycle per word on clk.
`timescale 1ns/1ns
module fbd_prog_mem
	import fbd_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic fetch_req,
	input wire logic [15:0] fetch_word,
	output logic instr_valid,
	output logic [15:0] instr
);
	// ------------------------------------------------------------------
	// Word output
	// ------------------------------------------------------------------
	// Between fetches the bus inverts every cycle, showing the inverse and the last word in turn, so a
	// decoder that samples without the strobe sees garbage or old data
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			instr_valid <= 1'b0;
			instr <= 16'h0000;
		end
		else if (fetch_req)
		begin
			instr_valid <= 1'b1;
			instr <= fetch_word;
		end
		else
		begin
			instr_valid <= 1'b0;
			instr <= ~instr;
		end
	end
endmodule

// *** verif/four_bit_core_instruction_decode_tb_top.sv ***
// Self-checking bench for the instruction decoder.
// Assumes the program memory model and the decoder share one clock.
`timescale 1ns/1ns
module four_bit_core_instruction_decode_tb_top
	import fbd_pkg::*;
;
	// ------------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------------
	logic clk = 1'b0; // Core clock, 8 ns
	logic reset = 1'b1; // Sync reset
	logic req = 1'b0; // Fetch request to memory
	logic [15:0] wd = 16'h0000; // Word to fetch
	logic [13:0] pc = 14'h0000;
	logic [13:0] address_reg = 14'h0000;
	logic [3:0] auto_saved_regs = 4'h0;
	logic irq_accept = 1'b0;
	logic segment_load = 1'b0;
	logic segment_value = 1'b0;
	logic instr_valid, dec_valid, op_form, segment_bit_reg;
	logic [15:0] instr;
	fbd_class_t op_class;
	logic [3:0] op_code, sub_sel, imm, interrupt_save_stack;
	logic [6:0] mem_addr, periph_addr, regfile_addr_field;
	logic [13:0] branch_target, return_stack_entry;
	logic [2:0] stack_ptr;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;

	always #4 clk = ~clk;

	fbd_prog_mem i_fbd_prog_mem (.clk(clk), .reset(reset), .fetch_req(req),
		.fetch_word(wd), .instr_valid(instr_valid), .instr(instr));
	fbd_decode i_fbd_decode (.clk(clk), .reset(reset), .instr_valid(instr_valid),
		.instr(instr), .pc(pc), .address_reg(address_reg),
		.auto_saved_regs(auto_saved_regs), .irq_accept(irq_accept),
		.segment_load(segment_load), .segment_value(segment_value),
		.dec_valid(dec_valid), .op_class(op_class), .op_code(op_code),
		.op_form(op_form), .sub_sel(sub_sel), .mem_addr(mem_addr),
		.periph_addr(periph_addr), .regfile_addr_field(regfile_addr_field),
		.imm(imm), .branch_target(branch_target),
		.return_stack_entry(return_stack_entry), .stack_ptr(stack_ptr),
		.segment_bit_reg(segment_bit_reg),
		.interrupt_save_stack(interrupt_save_stack));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	// Verdict and end of run
	task automatic close_out();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One comparison, four-state
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// Fetch one word at a pc; returns just after its decode lands
	task automatic run(input logic [15:0] w, input logic [13:0] p);
		@(posedge clk);
		req <= 1'b1;
		wd <= w;
		pc <= p;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
		#1;
		chk(16'(dec_valid), 16'h0001);
	endtask

	// Load the segment bit
	task automatic seg(input logic v);
		@(posedge clk);
		segment_load <= 1'b1;
		segment_value <= v;
		@(posedge clk);
		segment_load <= 1'b0;
		@(posedge clk);
		#1;
		chk(16'(segment_bit_reg), 16'(v));
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	// Branch to all four pages, in both segments
	task automatic sc_branch();
		logic [10:0] a;
		for (int s = 0; s < 2; s++)
		begin
			seg(s[0]);
			for (int p = 0; p < 4; p++)
			begin
				a = 11'h5a5 ^ 11'(p * 11'h111);
				run({3'b011, p[1:0], a}, 14'h0040);
				chk(16'(op_class), 16'(FBD_C_BR));
				chk(16'(branch_target), 16'({s[0], p[1:0], a}));
			end
		end
		seg(1'b0);
	endtask

	// Call then return, and system call entry split
	task automatic sc_call_ret();
		run(16'he7ff, 14'h0123);
		chk(16'(op_class), 16'(FBD_C_CALL));
		chk(16'(branch_target), 16'h07ff);
		chk(16'(stack_ptr), 16'h0006);
		run(16'h38e0, 14'h07ff);
		chk(16'(branch_target), 16'h0124);
		chk(16'(stack_ptr), 16'h0007);
		run(16'h3df9, 14'h0200);
		chk(16'(op_class), 16'(FBD_C_SYSCALL));
		chk(16'(branch_target), 16'h0509);
		run(16'h38e0, 14'h0509);
		chk(16'(branch_target), 16'h0201);
	endtask

	// Push address register, read back the stack entry, pop
	task automatic sc_push();
		// Address register changes on a rising edge like every other input
		@(posedge clk);
		address_reg <= 14'h2a5c;
		run(16'h38d0, 14'h0010);
		chk(16'(op_class), 16'(FBD_C_STACK));
		@(posedge clk);
		#1;
		chk(16'(return_stack_entry), 16'h2a5c);
		chk(16'(stack_ptr), 16'h0006);
		run(16'h38c0, 14'h0011);
		chk(16'(stack_ptr), 16'h0007);
	endtask

	// Operand fields of memory, peripheral and special forms
	task automatic sc_fields();
		run(16'h05b3, 14'h0000);
		chk(16'(op_class), 16'(FBD_C_ALU_RM));
		chk(16'(mem_addr), 16'h005b);
		chk(16'(regfile_addr_field), 16'h005b);
		run(16'h85b3, 14'h0000);
		chk(16'(op_class), 16'(FBD_C_ALU_MI));
		chk(16'({op_form, op_code, imm}), 16'h0103);
		run(16'h3eb6, 14'h0000);
		chk(16'(op_class), 16'(FBD_C_PERIPH));
		chk(16'(periph_addr), 16'h0066);
		run(16'h3890, 14'h0000);
		chk(16'(op_class), 16'(FBD_C_SPECIAL));
		chk(16'(sub_sel), 16'h0009);
		chk(16'(branch_target), 16'h2a5c);
		run(16'hb890, 14'h0000);
		chk(16'(op_class), 16'(FBD_C_NONE));
		// Transfer and skip classes, in both forms
		run(16'h4000, 14'h0000);
		chk(16'(op_class), 16'(FBD_C_XFER));
		run(16'h4800, 14'h0000);
		chk(16'(op_class), 16'(FBD_C_SKIP));
		run(16'he800, 14'h0000);
		chk(16'(op_class), 16'(FBD_C_XFER));
		run(16'hf000, 14'h0000);
		chk(16'(op_class), 16'(FBD_C_SKIP));
	endtask

	// Mid-run reset returns pointer, segment and outputs to idle
	task automatic sc_reset();
		seg(1'b1);
		run(16'h38d0, 14'h0020);
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk(16'({dec_valid, segment_bit_reg, stack_ptr}), 16'h0007);
		chk(16'(op_class), 16'(FBD_C_NONE));
		chk(16'(branch_target), 16'h0000);
	endtask

	// Interrupt acceptance copies the saved registers
	task automatic sc_irq();
		@(posedge clk);
		auto_saved_regs <= 4'hb;
		irq_accept <= 1'b1;
		@(posedge clk);
		irq_accept <= 1'b0;
		auto_saved_regs <= 4'h4;
		@(posedge clk);
		#1;
		chk(16'(interrupt_save_stack), 16'h000b);
		// No word fetched for a while, so the valid strobe has dropped
		chk(16'(dec_valid), 16'h0000);
	endtask

	// ------------------------------------------------------------------
	// Main sequence and hang guard
	// ------------------------------------------------------------------
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			close_out();
		end
	end

	initial
	begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk(16'({dec_valid, segment_bit_reg, stack_ptr}), 16'h0007);
		sc_branch();
		sc_call_ret();
		sc_push();
		sc_fields();
		sc_reset();
		sc_irq();
		close_out();
	end
endmodule
